/* File: rtl/tco_div.sv */
// Tick-enable divider: one output tick per 'divisor' input ticks
`timescale 1ns/100ps
module tco_div (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic tick_in,
    input wire logic [tco_pkg::TCO_DIVW-1:0] divisor_in,
    output logic tick_out
);
    import tco_pkg::*;

    logic [TCO_DIVW-1:0] cnt_q;
    logic last;

    // Last input tick of a period; divisor 1 passes every tick
    assign last = (cnt_q >= divisor_in - 4'h1);

    // Count input ticks; a divisor change applies at once to the period already running
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            cnt_q <= '0;
        end else if (tick_in) begin
            if (last) begin
                cnt_q <= '0;
            end else begin
                cnt_q <= cnt_q + 4'h1;
            end
        end
    end

    // Registered tick so downstream logic sees a clean pulse
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            tick_out <= 1'b0;
        end else begin
            tick_out <= tick_in & last;
        end
    end

endmodule // tco_div

/* File: rtl/tco_top.sv */
// Timer clock selection, prescalers, interval timer and oscillator trim registers
//
// Design decision made here: strobed register access.
`timescale 1ns/100ps

//
// Operation
// RULE1: interval source 00 int24, 01 ext, 10 lp32, 11 capture
// RULE2: interval prescaler codes give divide 1 to 4
// RULE3: capture prescaler codes give divide 2,4,6,8
// RULE4: capture source 00/01/10, code 11 disables it
// RULE5: external source is crystal if enabled, else pin
// RULE6: twelve-bit down counter clocked by interval ticks
// RULE7: tick after zero loads reload, no decrement
// RULE8: interrupt request on every reload
// RULE9: reload readable and writable while counter runs
// RULE10: terminal count copies reload value into counter
// RULE11: firmware switches sources only while both run
// RULE12: interval period scales with capture clock rate
// RULE13: fine offset bits add 7.5, 15, 30 kHz
// RULE14: five-bit gain sets offset step size
// RULE15: trim registers loaded by boot ROM values
// RULE16: transconductance 001 for 6 MHz, 011 for 12
// RULE17: crystal mode bit: oscillator or maximum bias test
// RULE18: low-power bit puts 32 kHz oscillator low-power
// RULE19: bias trim 00 mid, 01 high, 10 forbidden
// RULE20: four-bit frequency trim for 32 kHz oscillator
// RULE21: crystal enable bit, else clock from input pin
// RULE22: timer clock configuration resets to 0x8F
// RULE23: reload staged, committed on final byte write
module tco_top (
    input wire logic CLK_IN,
    input wire logic RESET_IN,
    // Plain register port
    input wire logic [7:0] ADDR_IN,
    input wire logic [7:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    output logic [7:0] RDATA_OUT,
    // Raw oscillator clocks, sampled as plain inputs
    input wire logic INT24_OSC_IN,
    input wire logic XTAL_OSC_IN,
    input wire logic EXT_CLOCK_PIN_IN,
    input wire logic LP32_OSC_IN,
    // Timer tick and interrupt outputs
    output logic CAPTURE_TICK_OUT,
    output logic INTERVAL_TICK_OUT,
    output logic INTERVAL_IRQ_OUT,
    // Oscillator control outputs
    output logic XTAL_ENABLE_OUT,
    output logic [2:0] IOSC_FOFFSET_OUT,
    output logic [4:0] IOSC_GAIN_OUT,
    output logic [2:0] XTAL_GM_OUT,
    output logic XTAL_TEST_MODE_OUT,
    output logic LPOSC_LOW_POWER_OUT,
    output logic [1:0] LPOSC_BIAS_OUT,
    output logic [3:0] LPOSC_FREQ_OUT
);
    import tco_pkg::*;

    // Register state
    logic [7:0] tmr_cfg_q;
    logic [7:0] clk_io_q;
    logic [7:0] iosc_trim_q;
    logic [7:0] crystal_oscillator_trim_q;
    logic [7:0] lposc_trim_q;
    logic [7:0] reload_stage_q;
    logic [11:0] reload_q;
    logic [11:0] count_q;
    logic [7:0] rdata_q;
    logic irq_q;

    // Source sampling
    logic [TCO_NSRC-1:0] raw_src;
    logic [TCO_NSRC-1:0] src_tick;

    // Clock chain
    tco_src_t isel;
    tco_src_t csel;
    logic [1:0] idiv_code;
    logic [1:0] cdiv_code;
    logic ext_tick;
    logic cap_src_tick;
    logic cap_tick;
    logic int_src_tick;
    logic int_tick;
    logic [TCO_DIVW-1:0] cap_divisor;
    logic [TCO_DIVW-1:0] int_divisor;

    // Bus decode
    logic wr_cfg;
    logic wr_clk_io;
    logic wr_iosc;
    logic wr_crystal_oscillator;
    logic wr_lposc;
    logic wr_rel_lo;
    logic wr_rel_hi;
    logic [1:0] bias_d;

    assign raw_src[TCO_I_INT24] = INT24_OSC_IN;
    assign raw_src[TCO_I_XTAL] = XTAL_OSC_IN;
    assign raw_src[TCO_I_PIN] = EXT_CLOCK_PIN_IN;
    assign raw_src[TCO_I_LP32] = LP32_OSC_IN;

    // Each source is synchronised, then rising edges become one-cycle ticks.
    // A source close to or above half of CLK_IN will alias; the timers only
    // see the edges this clock can resolve.
    generate
        for (genvar g = 0; g < TCO_NSRC; g++) begin : g_src
            logic meta_q;
            logic sync_q;
            logic prev_q;

            always_ff @(posedge CLK_IN) begin
                if (RESET_IN) begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                    prev_q <= 1'b0;
                end else begin
                    meta_q <= raw_src[g];
                    sync_q <= meta_q;
                    prev_q <= sync_q;
                end
            end

            assign src_tick[g] = sync_q & ~prev_q;
        end
    endgenerate

    // Field extraction from the timer clock configuration
    assign isel = tco_src_t'(tmr_cfg_q[TCO_ISEL_LSB +: 2]);
    assign idiv_code = tmr_cfg_q[TCO_IDIV_LSB +: 2];
    assign csel = tco_src_t'(tmr_cfg_q[TCO_CSEL_LSB +: 2]);
    assign cdiv_code = tmr_cfg_q[TCO_CDIV_LSB +: 2];

    // External source: crystal when enabled, otherwise the input pin
    assign ext_tick = clk_io_q[TCO_CRYSTAL_OSCILLATOR_EN_BIT]
                      ? src_tick[TCO_I_XTAL]
                      : src_tick[TCO_I_PIN]; // see RULE5 see RULE21

    // Capture source select; code 11 stops the capture clock
    always_comb begin
        case (csel)
            TCO_SRC_INT24: cap_src_tick = src_tick[TCO_I_INT24]; // see RULE4
            TCO_SRC_EXT: cap_src_tick = ext_tick;
            TCO_SRC_LP32: cap_src_tick = src_tick[TCO_I_LP32];
            TCO_SRC_ALT: cap_src_tick = 1'b0; // see RULE4
            default: cap_src_tick = 1'b0;
        endcase
    end

    // Capture divisor 2*(code+1): 2, 4, 6, 8
    assign cap_divisor = {1'b0, cdiv_code, 1'b0} + 4'h2; // see RULE3

    tco_div u_cap_div (
        .clk_in(CLK_IN),
        .reset_in(RESET_IN),
        .tick_in(cap_src_tick),
        .divisor_in(cap_divisor),
        .tick_out(cap_tick)
    );

    // Interval source select; code 11 follows the capture clock, so the
    // interval period scales with any change of the capture rate
    always_comb begin
        case (isel)
            TCO_SRC_INT24: int_src_tick = src_tick[TCO_I_INT24]; // see RULE1
            TCO_SRC_EXT: int_src_tick = ext_tick;
            TCO_SRC_LP32: int_src_tick = src_tick[TCO_I_LP32];
            TCO_SRC_ALT: int_src_tick = cap_tick; // see RULE1 see RULE12
            default: int_src_tick = 1'b0;
        endcase
    end

    // Interval divisor code+1: 1, 2, 3, 4
    assign int_divisor = {2'b00, idiv_code} + 4'h1; // see RULE2

    tco_div u_int_div (
        .clk_in(CLK_IN),
        .reset_in(RESET_IN),
        .tick_in(int_src_tick),
        .divisor_in(int_divisor),
        .tick_out(int_tick)
    );

    // Write decode
    assign wr_cfg = WR_IN & (ADDR_IN == TCO_OFS_TMR_CFG);
    assign wr_clk_io = WR_IN & (ADDR_IN == TCO_OFS_CLK_IO);
    assign wr_iosc = WR_IN & (ADDR_IN == TCO_OFS_IOSC_TRIM);
    assign wr_crystal_oscillator = WR_IN & (ADDR_IN == TCO_OFS_CRYSTAL_OSCILLATOR_TRIM);
    assign wr_lposc = WR_IN & (ADDR_IN == TCO_OFS_LPOSC_TRIM);
    assign wr_rel_lo = WR_IN & (ADDR_IN == TCO_OFS_RELOAD_LO);
    assign wr_rel_hi = WR_IN & (ADDR_IN == TCO_OFS_RELOAD_HI);

    // Timer clock configuration; default is 24 MHz / 6 / 4
    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            tmr_cfg_q <= TCO_TMR_CFG_RST; // see RULE22
        end else if (wr_cfg) begin
            // Glitch-free switching is left to firmware keeping both clocks alive
            tmr_cfg_q <= WDATA_IN; // see RULE11
        end
    end

    // Clock I/O configuration; only the crystal enable is used here
    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            clk_io_q <= TCO_CLK_IO_RST;
        end else if (wr_clk_io) begin
            clk_io_q <= WDATA_IN & TCO_CLK_IO_MASK; // see RULE21
        end
    end

    // Internal oscillator trim, written by the boot loader after reset
    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            iosc_trim_q <= TCO_TRIM_RST; // see RULE15
        end else if (wr_iosc) begin
            iosc_trim_q <= WDATA_IN; // see RULE13 see RULE14
        end
    end

    // Crystal trim; reserved bits are never stored
    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            crystal_oscillator_trim_q <= TCO_TRIM_RST; // see RULE15
        end else if (wr_crystal_oscillator) begin
            crystal_oscillator_trim_q <= WDATA_IN & TCO_CRYSTAL_OSCILLATOR_MASK; // see RULE17
        end
    end

    // The bias code 10 can stop oscillation, so a write of it keeps the
    // previous bias rather than risk losing the clock
    assign bias_d = (WDATA_IN[TCO_LBIAS_LSB +: 2] == TCO_LBIAS_BAD)
                    ? lposc_trim_q[TCO_LBIAS_LSB +: 2]
                    : WDATA_IN[TCO_LBIAS_LSB +: 2]; // see RULE19

    // Low-power oscillator trim
    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            lposc_trim_q <= TCO_TRIM_RST; // see RULE15
        end else if (wr_lposc) begin
            lposc_trim_q[TCO_LLP_BIT] <= WDATA_IN[TCO_LLP_BIT]; // see RULE18
            lposc_trim_q[6] <= 1'b0;
            lposc_trim_q[TCO_LBIAS_LSB +: 2] <= bias_d;
            lposc_trim_q[TCO_LFREQ_LSB +: 4] <= WDATA_IN[TCO_LFREQ_LSB +: 4]; // see RULE20
        end
    end

    // Low byte only stages; the counter never sees a half-written value
    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            reload_stage_q <= TCO_RELOAD_RST[7:0];
        end else if (wr_rel_lo) begin
            reload_stage_q <= WDATA_IN; // see RULE23
        end
    end

    // High nibble write commits both halves at once
    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            reload_q <= TCO_RELOAD_RST;
        end else if (wr_rel_hi) begin
            reload_q <= {WDATA_IN[3:0], reload_stage_q}; // see RULE23 see RULE9
        end
    end

    // Interval down counter: a tick at zero is spent reloading
    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            count_q <= TCO_COUNT_RST;
        end else if (int_tick) begin
            if (count_q == 12'h000) begin
                count_q <= reload_q; // see RULE7 see RULE10
            end else begin
                count_q <= count_q - 12'h001; // see RULE6
            end
        end
    end

    // One-cycle interrupt pulse on each reload
    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= int_tick & (count_q == 12'h000); // see RULE8
        end
    end

    // Read mux, registered: data stand in the cycle after the strobe
    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            rdata_q <= 8'h00;
        end else if (RD_IN) begin
            case (ADDR_IN)
                TCO_OFS_TMR_CFG: rdata_q <= tmr_cfg_q;
                TCO_OFS_CLK_IO: rdata_q <= clk_io_q;
                TCO_OFS_IOSC_TRIM: rdata_q <= iosc_trim_q;
                TCO_OFS_CRYSTAL_OSCILLATOR_TRIM: rdata_q <= crystal_oscillator_trim_q;
                TCO_OFS_LPOSC_TRIM: rdata_q <= lposc_trim_q;
                TCO_OFS_RELOAD_LO: rdata_q <= reload_q[7:0]; // see RULE9
                TCO_OFS_RELOAD_HI: rdata_q <= {4'h0, reload_q[11:8]};
                TCO_OFS_COUNT_LO: rdata_q <= count_q[7:0];
                TCO_OFS_COUNT_HI: rdata_q <= {4'h0, count_q[11:8]};
                default: rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    // Outputs
    assign RDATA_OUT = rdata_q;
    assign CAPTURE_TICK_OUT = cap_tick;
    assign INTERVAL_TICK_OUT = int_tick;
    assign INTERVAL_IRQ_OUT = irq_q;
    assign XTAL_ENABLE_OUT = clk_io_q[TCO_CRYSTAL_OSCILLATOR_EN_BIT];

    // Trim fields drive the analog oscillators directly
    assign IOSC_FOFFSET_OUT = iosc_trim_q[TCO_FOFS_LSB +: 3]; // see RULE13
    assign IOSC_GAIN_OUT = iosc_trim_q[TCO_GAIN_LSB +: 5]; // see RULE14
    assign XTAL_GM_OUT = crystal_oscillator_trim_q[TCO_XGM_LSB +: 3]; // see RULE16
    assign XTAL_TEST_MODE_OUT = crystal_oscillator_trim_q[TCO_XMODE_BIT]; // see RULE17
    assign LPOSC_LOW_POWER_OUT = lposc_trim_q[TCO_LLP_BIT]; // see RULE18
    assign LPOSC_BIAS_OUT = lposc_trim_q[TCO_LBIAS_LSB +: 2];
    assign LPOSC_FREQ_OUT = lposc_trim_q[TCO_LFREQ_LSB +: 4];

endmodule // tco_top

/* File: shared/tco_pkg.sv */
// Constants for the timer clock selection, interval timer and oscillator trim block
package tco_pkg;

    // Register offsets (byte addresses on the plain register port)
    localparam logic [7:0] TCO_OFS_TMR_CFG = 8'h31;
    localparam logic [7:0] TCO_OFS_CLK_IO = 8'h32;
    localparam logic [7:0] TCO_OFS_IOSC_TRIM = 8'h34;
    localparam logic [7:0] TCO_OFS_CRYSTAL_OSCILLATOR_TRIM = 8'h35;
    localparam logic [7:0] TCO_OFS_LPOSC_TRIM = 8'h36;
    localparam logic [7:0] TCO_OFS_RELOAD_LO = 8'h40;
    localparam logic [7:0] TCO_OFS_RELOAD_HI = 8'h41;
    localparam logic [7:0] TCO_OFS_COUNT_LO = 8'h42;
    localparam logic [7:0] TCO_OFS_COUNT_HI = 8'h43;

    // Reset values
    localparam logic [7:0] TCO_TMR_CFG_RST = 8'h8F;
    localparam logic [7:0] TCO_CLK_IO_RST = 8'h00;
    localparam logic [7:0] TCO_TRIM_RST = 8'h00;
    localparam logic [11:0] TCO_RELOAD_RST = 12'h03FF;
    localparam logic [11:0] TCO_COUNT_RST = 12'h0000;

    // Timer clock configuration fields
    localparam int TCO_ISEL_LSB = 0;
    localparam int TCO_IDIV_LSB = 2;
    localparam int TCO_CSEL_LSB = 4;
    localparam int TCO_CDIV_LSB = 6;

    // Clock I/O configuration fields
    localparam int TCO_CRYSTAL_OSCILLATOR_EN_BIT = 3;
    localparam logic [7:0] TCO_CLK_IO_MASK = 8'h1F;

    // Internal oscillator trim fields
    localparam int TCO_GAIN_LSB = 0;
    localparam int TCO_FOFS_LSB = 5;

    // Crystal oscillator trim fields; bits 7:5 and 1 read zero
    localparam int TCO_XMODE_BIT = 0;
    localparam int TCO_XGM_LSB = 2;
    localparam logic [7:0] TCO_CRYSTAL_OSCILLATOR_MASK = 8'h1D;

    // Low-power oscillator trim fields; bit 6 reads zero
    localparam int TCO_LFREQ_LSB = 0;
    localparam int TCO_LBIAS_LSB = 4;
    localparam int TCO_LLP_BIT = 7;
    localparam logic [7:0] TCO_LPOSC_MASK = 8'hBF;
    localparam logic [1:0] TCO_LBIAS_BAD = 2'b10;

    // Source codes
    typedef enum logic [1:0] {
        TCO_SRC_INT24 = 2'b00,
        TCO_SRC_EXT = 2'b01,
        TCO_SRC_LP32 = 2'b10,
        TCO_SRC_ALT = 2'b11
    } tco_src_t;

    // Clock source indices into the sampled source vector
    localparam int TCO_NSRC = 4;
    localparam int TCO_I_INT24 = 0;
    localparam int TCO_I_XTAL = 1;
    localparam int TCO_I_PIN = 2;
    localparam int TCO_I_LP32 = 3;

    // Divider counter width
    localparam int TCO_DIVW = 4;

endpackage

/* File: verif/tco_top_checker.sv */
// Port-level assertions for the timer clock and oscillator trim block
`timescale 1ns/100ps
module tco_top_checker import tco_pkg::*; (
    input wire logic CLK_IN,
    input wire logic RESET_IN,
    input wire logic [7:0] ADDR_IN,
    input wire logic [7:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    input wire logic [7:0] RDATA_OUT,
    input wire logic CAPTURE_TICK_OUT,
    input wire logic INTERVAL_TICK_OUT,
    input wire logic INTERVAL_IRQ_OUT,
    input wire logic XTAL_ENABLE_OUT,
    input wire logic [2:0] IOSC_FOFFSET_OUT,
    input wire logic [4:0] IOSC_GAIN_OUT,
    input wire logic [2:0] XTAL_GM_OUT,
    input wire logic XTAL_TEST_MODE_OUT,
    input wire logic LPOSC_LOW_POWER_OUT,
    input wire logic [1:0] LPOSC_BIAS_OUT,
    input wire logic [3:0] LPOSC_FREQ_OUT
);
    logic [7:0] cfg_q;
    logic [3:0] off_cnt_q;

    // Shadow of the timer config, rebuilt from bus writes
    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            cfg_q <= TCO_TMR_CFG_RST;
        end else if (WR_IN && ADDR_IN == TCO_OFS_TMR_CFG) begin
            cfg_q <= WDATA_IN;
        end
    end

    // Cycles since capture went off; the divider output registers may still flush a tick
    always_ff @(posedge CLK_IN) begin
        if (RESET_IN || cfg_q[5:4] != 2'h3) begin
            off_cnt_q <= 4'h0;
        end else if (off_cnt_q != 4'hF) begin
            off_cnt_q <= off_cnt_q + 4'h1;
        end
    end

    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RESET_IN);

    sequence s_lp_write;
        WR_IN && ADDR_IN == TCO_OFS_LPOSC_TRIM;
    endsequence
    sequence s_bias_bad;
        WR_IN && ADDR_IN == TCO_OFS_LPOSC_TRIM && WDATA_IN[5:4] == TCO_LBIAS_BAD;
    endsequence

    property p_irq_after_tick;
        INTERVAL_IRQ_OUT |-> $past(INTERVAL_TICK_OUT) ##1 !INTERVAL_IRQ_OUT;
    endproperty
    a_irq_after_tick: assert property (p_irq_after_tick)
        else $error("irq not one cycle after a tick");
    property p_rdata_idle;
        !$past(RD_IN) |-> RDATA_OUT == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data outside its cycle");
    property p_tick_pulse;
        INTERVAL_TICK_OUT |=> !INTERVAL_TICK_OUT;
    endproperty
    a_tick_pulse: assert property (p_tick_pulse)
        else $error("interval tick longer than a cycle");
    property p_cap_spacing;
        CAPTURE_TICK_OUT |=> !CAPTURE_TICK_OUT [*3];
    endproperty
    a_cap_spacing: assert property (p_cap_spacing)
        else $error("capture ticks closer than divide by two");
    property p_cap_off;
        off_cnt_q > 4'h5 |-> !CAPTURE_TICK_OUT && !(cfg_q[1:0] == 2'h3 && INTERVAL_TICK_OUT);
    endproperty
    a_cap_off: assert property (p_cap_off)
        else $error("tick while capture clock disabled");
    property p_xtal_en;
        WR_IN && ADDR_IN == TCO_OFS_CLK_IO |=> XTAL_ENABLE_OUT == $past(WDATA_IN[3]);
    endproperty
    a_xtal_en: assert property (p_xtal_en)
        else $error("crystal enable not taken");
    property p_iosc;
        WR_IN && ADDR_IN == TCO_OFS_IOSC_TRIM
            |=> {IOSC_FOFFSET_OUT, IOSC_GAIN_OUT} == $past(WDATA_IN);
    endproperty
    a_iosc: assert property (p_iosc)
        else $error("internal trim not taken");
    property p_crystal_oscillator;
        WR_IN && ADDR_IN == TCO_OFS_CRYSTAL_OSCILLATOR_TRIM |=> XTAL_GM_OUT == $past(WDATA_IN[4:2])
            && XTAL_TEST_MODE_OUT == $past(WDATA_IN[0]);
    endproperty
    a_crystal_oscillator: assert property (p_crystal_oscillator)
        else $error("crystal trim not taken");
    property p_lp_write;
        s_lp_write |=> LPOSC_LOW_POWER_OUT == $past(WDATA_IN[7])
            && LPOSC_FREQ_OUT == $past(WDATA_IN[3:0])
            && ($past(WDATA_IN[5:4]) == TCO_LBIAS_BAD || LPOSC_BIAS_OUT == $past(WDATA_IN[5:4]));
    endproperty
    a_lp_write: assert property (p_lp_write)
        else $error("low-power trim not taken");
    property p_lp_bias;
        s_bias_bad |=> $stable(LPOSC_BIAS_OUT);
    endproperty
    a_lp_bias: assert property (p_lp_bias)
        else $error("forbidden bias code stored");
endmodule // tco_top_checker

bind tco_top tco_top_checker u_chk (.CLK_IN(CLK_IN), .RESET_IN(RESET_IN), .ADDR_IN(ADDR_IN),
    .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT),
    .CAPTURE_TICK_OUT(CAPTURE_TICK_OUT), .INTERVAL_TICK_OUT(INTERVAL_TICK_OUT),
    .INTERVAL_IRQ_OUT(INTERVAL_IRQ_OUT), .XTAL_ENABLE_OUT(XTAL_ENABLE_OUT),
    .IOSC_FOFFSET_OUT(IOSC_FOFFSET_OUT), .IOSC_GAIN_OUT(IOSC_GAIN_OUT),
    .XTAL_GM_OUT(XTAL_GM_OUT), .XTAL_TEST_MODE_OUT(XTAL_TEST_MODE_OUT),
    .LPOSC_LOW_POWER_OUT(LPOSC_LOW_POWER_OUT), .LPOSC_BIAS_OUT(LPOSC_BIAS_OUT),
    .LPOSC_FREQ_OUT(LPOSC_FREQ_OUT));

/* File: verif/tco_top_test.sv */
// Directed testbench for the timer clock and oscillator trim block
`timescale 1ns/100ps
module tco_top_test;
    import tco_pkg::*;
    logic clk_in = 1'h0;
    logic reset_in = 1'h1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'h0;
    logic rd = 1'h0;
    logic [7:0] rdata;
    logic cap_tick, int_tick, irq;
    logic [2:0] gm;
    logic [1:0] bias;
    logic xen, xmode, lplow;
    logic [2:0] fofs;
    logic [4:0] gn;
    logic [3:0] lpfreq;
    logic [3:0] osc_q = 4'h0;
    int osc_cnt [4] = '{default: 0};
    int half_per [4] = '{4, 6, 8, 10};
    int miscompares = 0;
    int total_checks = 0;
    int gap;
    // Reset contents as {addr, value}; 0x50 is unmapped
    logic [15:0] rst_tab [8] = '{16'h318F, 16'h3200, 16'h3400, 16'h3500,
        16'h3600, 16'h40FF, 16'h4103, 16'h5000};
    // Rows {clock_io, config, 0 interval or 1 capture, expected tick gap}
    logic [31:0] src_tab [16] = '{32'h0000_0008, 32'h0004_0010, 32'h0008_0018,
        32'h000C_0020, 32'h0001_0010, 32'h0801_000C, 32'h0002_0014, 32'h0000_0110,
        32'h0040_0120, 32'h0080_0130, 32'h00C0_0140, 32'h0810_0118, 32'h0020_0128,
        32'h0003_0010, 32'h0033_0000, 32'h0033_0100};

    tco_top uut (.CLK_IN(clk_in), .RESET_IN(reset_in), .ADDR_IN(addr), .WDATA_IN(wdata),
        .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .INT24_OSC_IN(osc_q[0]),
        .XTAL_OSC_IN(osc_q[1]), .EXT_CLOCK_PIN_IN(osc_q[2]), .LP32_OSC_IN(osc_q[3]),
        .CAPTURE_TICK_OUT(cap_tick), .INTERVAL_TICK_OUT(int_tick), .INTERVAL_IRQ_OUT(irq),
        .XTAL_ENABLE_OUT(xen), .IOSC_FOFFSET_OUT(fofs), .IOSC_GAIN_OUT(gn), .XTAL_GM_OUT(gm),
        .XTAL_TEST_MODE_OUT(xmode), .LPOSC_LOW_POWER_OUT(lplow), .LPOSC_BIAS_OUT(bias),
        .LPOSC_FREQ_OUT(lpfreq));

    // 25 MHz system clock
    always #20 clk_in = ~clk_in;

    // Sources of 8, 12, 16, 20 cycles; kept slow so the synchroniser never aliases
    always @(posedge clk_in) begin
        for (int i = 0; i < 4; i++) begin
            if (osc_cnt[i] == half_per[i] - 1) begin
                osc_cnt[i] <= 0;
                osc_q[i] <= ~osc_q[i];
            end else begin
                osc_cnt[i] <= osc_cnt[i] + 1;
            end
        end
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Strobe for one cycle, then a released cycle so no strobe is set twice in a step
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge clk_in);
        wr <= 1'h0;
        @(posedge clk_in);
    endtask

    task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] seen;
        addr <= a;
        rd <= 1'h1;
        @(posedge clk_in);
        rd <= 1'h0;
        @(negedge clk_in);
        seen = rdata;
        check("rdata", {8'h00, seen}, {8'h00, exp});
        @(posedge clk_in);
    endtask

    // Cycles between the 2nd and 3rd pulse, so a config change has settled
    task automatic gap_of(input logic [7:0] sel, output int g);
        int n;
        int seen;
        logic p;
        g = 0;
        seen = 0;
        n = 0;
        while (seen < 3 && n < 4000) begin
            @(negedge clk_in);
            n++;
            p = (sel == 8'h00) ? int_tick : (sel == 8'h01) ? cap_tick : irq;
            if (p === 1'h1) begin
                seen++;
            end
            if (seen == 2) begin
                g++;
            end
        end
        if (seen < 3) begin
            g = 0;
        end
        @(posedge clk_in);
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (total_checks > 0 && miscompares == 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Hang guard, well beyond the roughly 10k cycles the tests need
    initial begin
        repeat (40000) @(posedge clk_in);
        miscompares++;
        give_verdict();
    end

    initial begin
        repeat (20) @(posedge clk_in);
        reset_in <= 1'h0;
        @(posedge clk_in);
        foreach (rst_tab[i]) rd_check(rst_tab[i][15:8], rst_tab[i][7:0]);
        wr_reg(8'h34, 8'hA5);
        rd_check(8'h34, 8'hA5);
        check("iosc", {8'h00, fofs, gn}, 16'h00A5);
        wr_reg(8'h35, 8'hFF);
        rd_check(8'h35, 8'h1D);
        check("xmode", {15'h0000, xmode}, 16'h0001);
        wr_reg(8'h35, 8'h1C);
        check("xgm", {13'h0000, gm}, 16'h0007);
        wr_reg(8'h36, 8'hFF);
        rd_check(8'h36, 8'hBF);
        check("lposc", {11'h000, lplow, lpfreq}, 16'h001F);
        wr_reg(8'h36, 8'h26);
        rd_check(8'h36, 8'h36);
        check("bias", {14'h0000, bias}, 16'h0003);
        // Every source, prescaler and disable code; ends on a stopped capture clock
        foreach (src_tab[i]) begin
            wr_reg(8'h32, src_tab[i][31:24]);
            check("xen", {15'h0000, xen}, {15'h0000, src_tab[i][27]});
            // All model sources keep running, so every switch is between live clocks
            wr_reg(8'h31, src_tab[i][23:16]);
            gap_of(src_tab[i][15:8], gap);
            check("tick_gap", gap[15:0], {8'h00, src_tab[i][7:0]});
        end
        // Mid-run reset restores the default configuration after the stopped capture source
        reset_in <= 1'h1;
        repeat (3) @(posedge clk_in);
        reset_in <= 1'h0;
        @(posedge clk_in);
        // Commit the reload while the default ticks are slow, so the first
        // tick from count zero already loads the new value
        wr_reg(8'h40, 8'h05);
        rd_check(8'h40, 8'hFF);
        wr_reg(8'h41, 8'hF0);
        rd_check(8'h40, 8'h05);
        rd_check(8'h41, 8'h00);
        wr_reg(8'h31, 8'h00);
        gap_of(8'h02, gap);
        check("irq_gap", gap[15:0], 16'h0030);
        wr_reg(8'h31, 8'h43);
        gap_of(8'h02, gap);
        check("irq_gap_cap", gap[15:0], 16'h00C0);
        give_verdict();
    end
endmodule // tco_top_test
